// File: design/rpf_filter.sv
// receive packet acceptance filter with wishbone register file
`timescale 1ns/100ps
module rpf_filter import rpf_pkg::*; (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // receive byte stream
    input  wire logic        rx_valid_i,
    input  wire logic [7:0]  rx_data_i,
    input  wire logic        rx_sof_i,
    input  wire logic        rx_eof_i,
    input  wire logic        rx_crc_ok_i,
    // decision
    output logic             done_o,
    output logic             accept_o,
    output logic      [5:0]  match_o
);
    typedef enum logic [1:0] {ST_IDLE, ST_RECV, ST_DECIDE} rpf_state_t;

    // ==========================================================
    // register file
    logic [7:0]  ctrl;
    logic [47:0] sta;
    logic [63:0] hash;
    logic [63:0] mask;
    logic [15:0] win_off;
    logic [15:0] exp_sum;
    logic [31:0] rd_val;
    logic [31:0] lanes;
    logic [31:0] wmerge;
    logic        wb_req;
    logic        wb_wr;

    rpf_state_t  state;
    rpf_state_t  next_state;

    assign wb_req = cyc_i & stb_i;
    assign wb_wr  = wb_req & we_i & ack_o;  // write lands with the ack edge
    assign lanes  = {{8{sel_i[3]}}, {8{sel_i[2]}},
                     {8{sel_i[1]}}, {8{sel_i[0]}}};
    assign wmerge = (rd_val & ~lanes) | (dat_i & lanes);

    // read mux, also the base for byte-lane merging on writes
    always_comb begin
        case (adr_i)
            ADR_CTRL:    rd_val = {24'h000000, ctrl};
            ADR_STA_LO:  rd_val = sta[31:0];
            ADR_STA_HI:  rd_val = {16'h0000, sta[47:32]};
            ADR_HASH_LO: rd_val = hash[31:0];
            ADR_HASH_HI: rd_val = hash[63:32];
            ADR_MASK_LO: rd_val = mask[31:0];
            ADR_MASK_HI: rd_val = mask[63:32];
            ADR_OFFSET:  rd_val = {16'h0000, win_off};
            ADR_SUM:     rd_val = {16'h0000, exp_sum};
            ADR_STATUS:  rd_val = {15'h0000, state != ST_IDLE, 7'h00,
                                   accept_o, 2'h0, match_o};
            default:     rd_val = REG_RST;
        endcase
    end

    // one wait state: ack follows the request by one edge, then drops
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= REG_RST;
        end else begin
            ack_o <= wb_req & ~ack_o;
            if (wb_req & ~ack_o) begin
                dat_o <= rd_val;
            end
        end
    end

    // software writes; unmapped and status writes are dropped
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl    <= CTRL_RST;
            sta     <= {REG_RST[15:0], REG_RST};
            hash    <= {REG_RST, REG_RST};
            mask    <= {REG_RST, REG_RST};
            win_off <= REG_RST[15:0];
            exp_sum <= REG_RST[15:0];
        end else if (wb_wr) begin
            case (adr_i)
                ADR_CTRL:    ctrl          <= wmerge[7:0];
                ADR_STA_LO:  sta[31:0]     <= wmerge;
                ADR_STA_HI:  sta[47:32]    <= wmerge[15:0];
                ADR_HASH_LO: hash[31:0]    <= wmerge;
                ADR_HASH_HI: hash[63:32]   <= wmerge;
                ADR_MASK_LO: mask[31:0]    <= wmerge;
                ADR_MASK_HI: mask[63:32]   <= wmerge;
                ADR_OFFSET:  win_off       <= wmerge[15:0];
                ADR_SUM:     exp_sum       <= wmerge[15:0];
                default:     ;
            endcase
        end
    end

    // ==========================================================
    // frame tracking
    logic        take;
    logic        first;
    logic [15:0] pos;
    logic [15:0] cur_pos;
    logic [7:0]  sta_byte;
    logic        in_da;

    // bytes outside a frame are ignored until the next start
    assign take     = rx_valid_i & (rx_sof_i | (state == ST_RECV));
    assign first    = rx_valid_i & rx_sof_i;
    assign cur_pos  = rx_sof_i ? 16'h0000 : pos;
    assign in_da    = cur_pos < DA_LEN;
    assign sta_byte = sta[8 * cur_pos[2:0] +: 8];

    // byte position from the first address byte, saturating
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pos <= 16'h0000;
        end else if (take) begin
            pos <= (cur_pos == POS_MAX) ? POS_MAX : cur_pos + 16'h0001;
        end
    end

    // frame state; a start during the decision cycle is honoured
    always_comb begin
        case (state)
            ST_RECV: begin
                next_state = (take & rx_eof_i) ? ST_DECIDE : ST_RECV;
            end
            ST_IDLE, ST_DECIDE: begin
                if (first) begin
                    next_state = rx_eof_i ? ST_DECIDE : ST_RECV;
                end else begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ==========================================================
    // destination address criteria
    logic sta_ok;
    logic bc_ok;
    logic grp;
    logic crc_good;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sta_ok <= 1'b0;
            bc_ok  <= 1'b0;
            grp    <= 1'b0;
        end else if (take & in_da) begin
            sta_ok <= (first | sta_ok) & (rx_data_i == sta_byte);
            bc_ok  <= (first | bc_ok) & (rx_data_i == 8'hFF);
            if (first) begin
                grp <= rx_data_i[0];
            end
        end
    end

    // frame check status sampled with the last byte
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            crc_good <= 1'b0;
        end else if (take & rx_eof_i) begin
            crc_good <= rx_crc_ok_i;
        end
    end

    // hash over the six address bytes
    logic [31:0] crc;
    logic [5:0]  hash_idx;
    logic        hash_hit;

    rpf_crc u_crc (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .clr_i  (first),
        .en_i   (take & in_da),
        .byte_i (rx_data_i),
        .crc_o  (crc)
    );

    assign hash_idx = crc[HASH_MSB:HASH_LSB];
    assign hash_hit = (hash == 64'h0) | hash[hash_idx];

    // ==========================================================
    // pattern window checksum
    logic [16:0] rel;
    logic        in_win;
    logic        incl;
    logic        win_done;
    logic [15:0] cs_sum;

    assign rel    = {1'b0, cur_pos} - {1'b0, win_off};
    assign in_win = (cur_pos >= win_off) & (rel[16:6] == 11'h000);
    // mask bit k of byte n is bit 8n+k, selecting window byte 8n+k
    assign incl   = take & in_win & mask[rel[5:0]];

    rpf_csum u_csum (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .clr_i  (first),
        .en_i   (incl),      // excluded bytes never reach the sum
        .byte_i (rx_data_i),
        .sum_o  (cs_sum)
    );

    // window counts only when its last byte really arrived
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            win_done <= 1'b0;
        end else if (take) begin
            win_done <= (~first & win_done)
                      | (in_win & (rel[5:0] == WIN_LAST));
        end
    end

    // ==========================================================
    // wake frame search in the data field
    logic [2:0] ff_run;
    logic [2:0] bidx;
    logic [3:0] copies;
    logic       in_addr;
    logic       wake_hit;
    logic [7:0] wake_byte;

    assign wake_byte = sta[8 * bidx +: 8];

    // six FF then sixteen address copies; a miss restarts the hunt
    always_ff @(posedge clk_i) begin
        if (rst_i | first) begin
            ff_run   <= 3'h0;
            bidx     <= 3'h0;
            copies   <= 4'h0;
            in_addr  <= 1'b0;
            wake_hit <= 1'b0;
        end else if (take & (cur_pos >= DATA_POS) & ~wake_hit) begin
            if (!in_addr) begin
                if (ff_run == SYNC_LEN && rx_data_i == sta[7:0]) begin
                    in_addr <= 1'b1;
                    bidx    <= 3'h1;
                    copies  <= 4'h0;
                end else if (rx_data_i == 8'hFF) begin
                    ff_run <= (ff_run == SYNC_LEN) ? SYNC_LEN : ff_run + 3'h1;
                end else begin
                    ff_run <= 3'h0;
                end
            end else if (rx_data_i == wake_byte) begin
                if (bidx == ADDR_LAST) begin
                    bidx <= 3'h0;
                    if (copies == COPY_LAST) begin
                        wake_hit <= 1'b1;
                    end else begin
                        copies <= copies + 4'h1;
                    end
                end else begin
                    bidx <= bidx + 3'h1;
                end
            end else begin
                in_addr <= 1'b0;
                bidx    <= 3'h0;
                ff_run  <= (rx_data_i == 8'hFF) ? 3'h1 : 3'h0;
            end
        end
    end

    // ==========================================================
    // decision
    logic       da_done;
    logic [5:0] met;
    logic [5:0] en_vec;
    logic       crit;
    logic       acc;

    assign da_done = pos >= DA_LEN;
    assign en_vec  = {ctrl[CB_STA], ctrl[CB_PAT], ctrl[CB_WAKE],
                      ctrl[CB_HASH], ctrl[CB_GRP], ctrl[CB_ALL]};

    always_comb begin
        met          = 6'h00;
        met[MB_STA]  = sta_ok & da_done;
        met[MB_PAT]  = win_done & (cs_sum == exp_sum);
        met[MB_WAKE] = wake_hit & sta_ok & da_done;
        met[MB_HASH] = hash_hit & da_done;
        met[MB_GRP]  = grp;
        met[MB_ALL]  = bc_ok & da_done;
        // disabled criteria drop out of both forms
        if (ctrl[CB_COMB]) begin
            crit = &(met | ~en_vec);
        end else begin
            crit = (en_vec == 6'h00) | (|(met & en_vec));
        end
        acc = crit & (~ctrl[CB_FCS] | crc_good);
    end

    // results held until the next decision
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done_o   <= 1'b0;
            accept_o <= 1'b0;
            match_o  <= 6'h00;
        end else begin
            done_o <= (state == ST_DECIDE);
            if (state == ST_DECIDE) begin
                accept_o <= acc;
                match_o  <= met;
            end
        end
    end

    // ==========================================================
    // checks
    logic [47:0] da_cap;

    // independent capture of the address bytes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            da_cap <= 48'h0;
        end else if (take & in_da) begin
            da_cap[8 * cur_pos[2:0] +: 8] <= rx_data_i;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_frame_end;
        take && rx_eof_i;
    endsequence
    sequence s_answer;
        ##1 (state == ST_DECIDE) ##1 done_o;
    endsequence

    AST_DONE_TIME: assert property (s_frame_end |-> s_answer)
        else $error("decision not two cycles after frame end");
    AST_STATION: assert property (done_o |-> match_o[MB_STA] ==
        ($past(da_cap) == $past(sta) && $past(pos) >= DA_LEN))
        else $error("station criterion wrong");
    AST_GROUP: assert property (done_o |-> match_o[MB_GRP] ==
        $past(da_cap[0]))
        else $error("group criterion wrong");
    AST_ALLONES: assert property (done_o |-> match_o[MB_ALL] ==
        ($past(da_cap) == 48'hFFFF_FFFF_FFFF && $past(pos) >= DA_LEN))
        else $error("all-ones criterion wrong");
    AST_PAT_SHORT: assert property (((state == ST_DECIDE) &&
        ({1'b0, pos} < {1'b0, win_off} + WIN_SPAN)) |=> !match_o[MB_PAT])
        else $error("short frame passed pattern");
    AST_PAT_SUM: assert property (((state == ST_DECIDE) && win_done)
        |=> match_o[MB_PAT] == ($past(cs_sum) == $past(exp_sum)))
        else $error("pattern compare wrong");
    AST_HASH_EMPTY: assert property (((state == ST_DECIDE) &&
        hash == 64'h0 && da_done) |=> match_o[MB_HASH])
        else $error("empty hash table did not pass");
    AST_WAKE_STA: assert property (done_o && match_o[MB_WAKE]
        |-> $past(da_cap) == $past(sta))
        else $error("wake without station match");
    AST_AND: assert property ((done_o && $past(ctrl[CB_COMB]) &&
        |($past(en_vec) & ~match_o)) |-> !accept_o)
        else $error("and form accepted a failing frame");
    AST_OR: assert property ((done_o && !$past(ctrl[CB_COMB]) &&
        |($past(en_vec) & match_o) &&
        !($past(ctrl[CB_FCS]) && !$past(crc_good))) |-> accept_o)
        else $error("or form rejected a passing frame");
    AST_WB_ACK: assert property ((wb_req && !ack_o) |=> ack_o ##1 !ack_o)
        else $error("bus ack not single cycle");
endmodule

// File: pkg/rpf_pkg.sv
// constants shared by the receive packet filter design files
package rpf_pkg;
    // ==========================================================
    // register byte offsets
    localparam logic [7:0] ADR_CTRL    = 8'h00;
    localparam logic [7:0] ADR_STA_LO  = 8'h04;
    localparam logic [7:0] ADR_STA_HI  = 8'h08;
    localparam logic [7:0] ADR_HASH_LO = 8'h0C;
    localparam logic [7:0] ADR_HASH_HI = 8'h10;
    localparam logic [7:0] ADR_MASK_LO = 8'h14;
    localparam logic [7:0] ADR_MASK_HI = 8'h18;
    localparam logic [7:0] ADR_OFFSET  = 8'h1C;
    localparam logic [7:0] ADR_SUM     = 8'h20;
    localparam logic [7:0] ADR_STATUS  = 8'h24;
    // ==========================================================
    // reset values
    localparam logic [7:0]  CTRL_RST = 8'hA1;
    localparam logic [31:0] REG_RST  = 32'h0000_0000;
    // ==========================================================
    // control bit positions
    localparam int CB_STA  = 7;
    localparam int CB_COMB = 6;
    localparam int CB_FCS  = 5;
    localparam int CB_PAT  = 4;
    localparam int CB_WAKE = 3;
    localparam int CB_HASH = 2;
    localparam int CB_GRP  = 1;
    localparam int CB_ALL  = 0;
    // criterion positions in the match vector
    localparam int MB_STA  = 5;
    localparam int MB_PAT  = 4;
    localparam int MB_WAKE = 3;
    localparam int MB_HASH = 2;
    localparam int MB_GRP  = 1;
    localparam int MB_ALL  = 0;
    // status field positions
    localparam int SB_ACC  = 8;
    localparam int SB_BUSY = 16;
    // ==========================================================
    // frame geometry and counts
    localparam logic [15:0] DA_LEN    = 16'h0006;
    localparam logic [15:0] DATA_POS  = 16'h000E;
    localparam logic [15:0] POS_MAX   = 16'hFFFF;
    localparam logic [16:0] WIN_SPAN  = 17'h00040;
    localparam logic [5:0]  WIN_LAST  = 6'h3F;
    localparam logic [2:0]  SYNC_LEN  = 3'h6;
    localparam logic [2:0]  ADDR_LAST = 3'h5;
    localparam logic [3:0]  COPY_LAST = 4'hF;
    // ==========================================================
    // hash crc
    localparam logic [31:0] CRC_INIT = 32'hFFFF_FFFF;
    localparam logic [31:0] CRC_POLY = 32'hEDB8_8320;
    localparam int HASH_MSB = 28;
    localparam int HASH_LSB = 23;
endpackage

// File: design/rpf_csum.sv
// ones-complement byte checksum accumulator for the pattern window
`timescale 1ns/100ps
module rpf_csum import rpf_pkg::*; (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // byte stream
    input  wire logic       clr_i,
    input  wire logic       en_i,
    input  wire logic [7:0] byte_i,
    // result
    output logic [15:0]     sum_o
);
    logic [15:0] acc;
    logic [7:0]  hi;
    logic        pend;
    logic [15:0] base;
    logic        base_pend;

    // end-around carry add, one fold is enough for two 16-bit terms
    function automatic logic [15:0] oc_add(input logic [15:0] a,
                                           input logic [15:0] b);
        logic [16:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[15:0] + {15'h0000, s[16]};
    endfunction

    // a clear in the same cycle as a byte restarts with that byte
    always_comb begin
        base      = clr_i ? REG_RST[15:0] : acc;
        base_pend = clr_i ? 1'b0 : pend;
    end

    // only included bytes arrive, so pairing skips gaps
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acc  <= REG_RST[15:0];
            hi   <= REG_RST[7:0];
            pend <= 1'b0;
        end else if (en_i) begin
            if (!base_pend) begin
                hi   <= byte_i;         // first of pair is high byte
                acc  <= base;
                pend <= 1'b1;
            end else begin
                acc  <= oc_add(base, {hi, byte_i});
                pend <= 1'b0;
            end
        end else if (clr_i) begin
            acc  <= REG_RST[15:0];
            pend <= 1'b0;
        end
    end

    // odd byte out is padded with a zero low byte, then complemented
    assign sum_o = ~(pend ? oc_add(acc, {hi, 8'h00}) : acc);
endmodule

// File: design/rpf_crc.sv
// byte-wide crc over the destination address for the hash lookup
`timescale 1ns/100ps
module rpf_crc import rpf_pkg::*; (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // byte stream
    input  wire logic        clr_i,
    input  wire logic        en_i,
    input  wire logic [7:0]  byte_i,
    // running crc
    output logic [31:0]      crc_o
);
    logic [31:0] base;

    // reflected crc, least significant data bit first
    function automatic logic [31:0] step(input logic [31:0] c_in,
                                         input logic [7:0] d);
        logic [31:0] c;
        c = c_in;
        for (int i = 0; i < 8; i++) begin
            c = (c[0] ^ d[i]) ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction

    assign base = clr_i ? CRC_INIT : crc_o;

    // crc register, restarted at the first address byte
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            crc_o <= CRC_INIT;
        end else if (en_i) begin
            crc_o <= step(base, byte_i);
        end else if (clr_i) begin
            crc_o <= CRC_INIT;
        end
    end
endmodule

// File: bench/rpf_rx_src.sv
// behavioural source of received frame bytes for the filter
`timescale 1ns/100ps
module rpf_rx_src (
    // clock
    input  wire logic  clk_i,
    // byte stream toward the filter
    output logic       valid_o,
    output logic [7:0] data_o,
    output logic       sof_o,
    output logic       eof_o,
    output logic       crc_ok_o
);
    // ==========================================================
    // frame storage and idle behaviour
    logic [7:0] buf_q [256];
    logic       busy = 1'b0;
    initial begin
        valid_o = 1'b0;
        data_o = 8'h00;
        sof_o = 1'b0;
        eof_o = 1'b0;
        crc_ok_o = 1'b0;
    end
    // released lines keep moving so a stale byte never looks fresh
    always @(posedge clk_i) begin
        if (!busy) begin
            data_o <= ~data_o;
            crc_ok_o <= ~crc_ok_o;
        end
    end
    // one frame; slow puts an idle cycle between bytes
    task automatic send(input int len, input bit ok, input bit slow);
        busy = 1'b1;
        for (int i = 0; i < len; i++) begin
            if (slow && i > 0) begin
                @(posedge clk_i);
                valid_o <= 1'b0;
                data_o <= ~data_o;
            end
            @(posedge clk_i);
            valid_o <= 1'b1;
            data_o <= buf_q[i];
            sof_o <= (i == 0);
            eof_o <= (i == len - 1);
            crc_ok_o <= (i == len - 1) ? ok : ~crc_ok_o;
        end
        @(posedge clk_i);
        valid_o <= 1'b0;
        sof_o <= 1'b0;
        eof_o <= 1'b0;
        busy = 1'b0;
    endtask
endmodule

// File: bench/tb_top.sv
// self-checking bench for the receive packet filter
`timescale 1ns/100ps
module tb_top import rpf_pkg::*; ;
    // ==========================================================
    // signals and case tables
    typedef struct {int sel; int len; bit wk, ok; logic [5:0] m;} rpf_row_t;
    logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
    logic        rx_valid_i, rx_sof_i, rx_eof_i, rx_crc_ok_i;
    logic        done_o, accept_o;
    logic [7:0]  adr_i, rx_data_i;
    logic [3:0]  sel_i;
    logic [31:0] dat_i, dat_o, rd;
    logic [5:0]  match_o;
    int          error_cnt = 0, n_tests = 0, cyc_cnt = 0;
    logic [3:0]  wsel = 4'hF;
    logic [63:0] hbit;
    logic [5:0]  hm;
    // station, all-ones, group, foreign unicast
    logic [7:0]  das [4][6] = '{'{8'h02, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55},
        '{6{8'hFF}}, '{8'h01, 8'h00, 8'h5E, 8'h00, 8'h00, 8'h01},
        '{8'h04, 8'h10, 8'h20, 8'h30, 8'h40, 8'h50}};
    // criteria met per frame, whatever the enables
    rpf_row_t    rows [6] = '{'{0, 64, 0, 1, 6'h34}, '{0, 40, 0, 1, 6'h24},
        '{0, 120, 1, 1, 6'h3C}, '{1, 64, 0, 1, 6'h07},
        '{2, 64, 0, 1, 6'h06}, '{3, 64, 0, 0, 6'h04}};
    logic [7:0]  ctls [5] = '{8'hA1, 8'h70, 8'h4E, 8'h00, 8'h96};

    rpf_filter dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
        .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i),
        .rx_sof_i(rx_sof_i), .rx_eof_i(rx_eof_i),
        .rx_crc_ok_i(rx_crc_ok_i), .done_o(done_o),
        .accept_o(accept_o), .match_o(match_o));
    rpf_rx_src src (.clk_i(clk_i), .valid_o(rx_valid_i),
        .data_o(rx_data_i), .sof_o(rx_sof_i), .eof_o(rx_eof_i),
        .crc_ok_o(rx_crc_ok_i));

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    // hang guard, far above the few thousand cycles needed
    always @(posedge clk_i) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 30000) begin
            error_cnt++;
            complete_run();
        end
    end
    // ==========================================================
    // helpers
    task automatic check(input logic [31:0] s, e, input string msg);
        n_tests++;
        if (s !== e) begin
            error_cnt++;
            $display("BAD %0t %s seen %h want %h", $time, msg, s, e);
        end
    endtask
    task automatic complete_run;
        $display("tests %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // classic cycle: hold until ack is sampled, then release
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= wsel;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask
    // ones-complement sum, skipped bytes close up, high byte first
    function automatic logic [15:0] psum(input logic [63:0] m, input int o);
        logic [16:0] s;
        logic        hi;
        logic [7:0]  b;
        s = 17'h00000;
        hi = 1'b1;
        for (int i = 0; i < 64; i++) if (m[i]) begin
            b = src.buf_q[o + i];
            s = s + (hi ? {b, 8'h00} : {8'h00, b});
            s = {1'b0, s[15:0]} + 17'(s[16]);
            hi = ~hi;
        end
        return ~s[15:0];
    endfunction
    // reflected address crc, least significant bit of each byte first
    function automatic logic [5:0] hidx(input int sel);
        logic [31:0] c;
        logic        b;
        c = CRC_INIT;
        for (int i = 0; i < 48; i++) begin
            b = das[sel][i / 8][i % 8];
            c = (c[0] ^ b) ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        end
        return c[HASH_MSB:HASH_LSB];
    endfunction
    function automatic logic acc(input logic [7:0] c, input logic [5:0] m,
                                 input logic ok);
        logic [5:0] en;
        en = {c[CB_STA], c[CB_PAT], c[CB_WAKE],
              c[CB_HASH], c[CB_GRP], c[CB_ALL]};
        if (c[CB_FCS] && !ok) return 1'b0;
        if (en == 6'h00) return 1'b1;
        return c[CB_COMB] ? &(m | ~en) : |(m & en);
    endfunction
    task automatic build(input rpf_row_t r);
        for (int i = 0; i < 256; i++) src.buf_q[i] = 8'(i * 7 + 3);
        for (int i = 0; i < 6; i++) src.buf_q[i] = das[r.sel][i];
        for (int i = 0; i < 102 && r.wk; i++)
            src.buf_q[14 + i] = (i < 6) ? 8'hFF : das[0][(i - 6) % 6];
    endtask
    // decision comes in the second cycle after the last byte
    task automatic frame(input logic [7:0] c, input rpf_row_t r, input bit sl);
        build(r);
        src.send(r.len, r.ok, sl);
        repeat (2) @(posedge clk_i);
        check(32'(done_o), 32'h1, "done");
        check(32'(match_o[5:4]), 32'(r.m[5:4]), "m hi");
        check(32'(match_o[3:0]), 32'(r.m[3:0]), "m lo");
        check(32'(accept_o), 32'(acc(c, r.m, r.ok)), "accept");
        @(posedge clk_i);
        check(32'(done_o), 32'h0, "done len");
    endtask
    // ==========================================================
    // main sequence
    initial begin
        rst_i = 1'b1;
        cyc_i = 1'b0;
        stb_i = 1'b0;
        we_i = 1'b0;
        adr_i = 8'h00;
        sel_i = 4'h0;
        dat_i = 32'h0;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(0, ADR_CTRL, 0, rd);
        check(rd, 32'(CTRL_RST), "ctrl reset");
        wb(0, ADR_STA_LO, 0, rd);
        check(rd, REG_RST, "station reset");
        wb(1, 8'h40, 32'hFFFF_FFFF, rd);
        wb(0, 8'h40, 0, rd);
        check(rd, 32'h0, "unmapped");
        wb(1, ADR_STATUS, 32'h1FF, rd);
        wb(0, ADR_STATUS, 0, rd);
        check(rd, 32'h0, "status");
        // only the byte lane that is enabled may land
        wsel = 4'h2;
        wb(1, ADR_STA_LO, 32'hFFFF_FFFF, rd);
        wsel = 4'hF;
        wb(0, ADR_STA_LO, 0, rd);
        check(rd, 32'h0000_FF00, "byte lane");
        $display("test registers done");
        // everything set up before the control table is stepped through
        wb(1, ADR_STA_LO, 32'h3322_1102, rd);
        wb(1, ADR_STA_HI, 32'h0000_5544, rd);
        wb(1, ADR_OFFSET, 32'h0, rd);
        wb(1, ADR_MASK_LO, 32'h3F, rd);
        build(rows[0]);
        wb(1, ADR_SUM, 32'(psum(64'h3F, 0)), rd);
        foreach (ctls[c]) begin
            wb(1, ADR_CTRL, 32'(ctls[c]), rd);
            wb(0, ADR_CTRL, 0, rd);
            check(rd, 32'(ctls[c]), "ctrl rw");
            foreach (rows[r]) frame(ctls[c], rows[r], r % 2);
        end
        $display("test frame table done");
        // sparse mask at offset 4, last bit on the final crc byte
        wb(1, ADR_CTRL, 32'h50, rd);
        wb(1, ADR_OFFSET, 32'h4, rd);
        wb(1, ADR_MASK_LO, 32'h15, rd);
        wb(1, ADR_MASK_HI, 32'h8000_0000, rd);
        build('{3, 68, 0, 1, 6'h14});
        wb(1, ADR_SUM, 32'(psum(64'h8000_0000_0000_0015, 4)), rd);
        frame(8'h50, '{3, 68, 0, 1, 6'h14}, 0);
        frame(8'h50, '{3, 67, 0, 1, 6'h04}, 1);
        $display("test window done");
        // one table bit, at the index of the bench's own address crc
        hbit = 64'h1 << hidx(3);
        wb(1, ADR_CTRL, 32'h04, rd);
        wb(1, ADR_HASH_LO, hbit[31:0], rd);
        wb(1, ADR_HASH_HI, hbit[63:32], rd);
        wb(0, ADR_HASH_HI, 0, rd);
        check(rd, hbit[63:32], "hash rw");
        frame(8'h04, '{3, 64, 0, 1, 6'h04}, 0);
        hm = {3'h0, hidx(2) == hidx(3), 2'h2};
        frame(8'h04, '{2, 64, 0, 1, hm}, 1);
        $display("test hash done");
        // second reset in mid-run
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        check(32'({done_o, accept_o, match_o}), 32'h0, "outputs reset");
        wb(0, ADR_CTRL, 0, rd);
        check(rd, 32'(CTRL_RST), "ctrl reset again");
        $display("test reset done");
        complete_run();
    end
endmodule
